// ==== pxc_pkg.sv ====
/*
  Constants for the extended configuration register bank of a 10/100
  transceiver: management register numbers, extended offsets, field
  positions, reset values, frame limits and wake pulse timing.
  Assumes a 250 MHz device clock and a management front end that turns
  serial frames into single-cycle register read and write strobes.
*/
package pxc_pkg;

  // Management register numbers of the indirect pair
  localparam logic [4:0]  PXC_IND_ADDR_REG = 5'h1e;
  localparam logic [4:0]  PXC_IND_DATA_REG = 5'h1f;

  // Extended register offsets
  localparam logic [15:0] PXC_TEN_MEG_PWR  = 16'h200a;
  localparam logic [15:0] PXC_COMBO        = 16'h4000;
  localparam logic [15:0] PXC_PAD          = 16'h4001;
  localparam logic [15:0] PXC_COMBO_TWO    = 16'h4003;
  localparam logic [15:0] PXC_WAKE_HIGH    = 16'h4004;
  localparam logic [15:0] PXC_WAKE_MID     = 16'h4005;
  localparam logic [15:0] PXC_WAKE_LOW     = 16'h4006;

  // Reset values (clock direction bit is patched from the strap)
  localparam logic [15:0] PXC_TEN_MEG_RST  = 16'hca02;
  localparam logic [15:0] PXC_COMBO_RST    = 16'h0000;
  localparam logic [15:0] PXC_PAD_RST      = 16'h80ef;
  localparam logic [15:0] PXC_COMBO2_RST   = 16'h0260;
  localparam logic [15:0] PXC_WAKE_RST     = 16'h0000;

  // Field positions
  localparam int PXC_IDLE_GATE_BIT  = 10;
  localparam int PXC_LOOP_BIT       = 11;
  localparam int PXC_LONG_FRAME_BIT = 5;
  localparam int PXC_CV_SRC_BIT     = 4;
  localparam int PXC_WAKE_EN_BIT    = 2;
  localparam int PXC_REDUCED_BIT    = 1;
  localparam int PXC_CLK_DIR_BIT    = 0;
  localparam int PXC_IRQ_SRC_BIT    = 15;
  localparam int PXC_MAC_DRV_LSB    = 4;
  localparam int PXC_MGMT_DRV_LSB   = 2;
  localparam int PXC_JITTER_BIT     = 14;
  localparam int PXC_SHAPE_LSB      = 7;
  localparam int PXC_TX_ISO_BIT     = 6;
  localparam int PXC_RX_ISO_BIT     = 5;

  // Receive frame limits in bytes
  localparam logic [15:0] PXC_LONG_FRAME_LEN  = 16'h4800;
  localparam logic [15:0] PXC_SHORT_FRAME_LEN = 16'h1200;

  // Wake pulse widths, in ns, and their cycle counts
  localparam int PXC_CLK_PERIOD_NS = 4;
  localparam int PXC_PULSE_10US_NS  = 10000;
  localparam int PXC_PULSE_100US_NS = 100000;
  localparam int PXC_PULSE_1MS_NS   = 1000000;
  localparam int PXC_PULSE_10MS_NS  = 10000000;
  localparam int PXC_PULSE_10US_CYC  = PXC_PULSE_10US_NS / PXC_CLK_PERIOD_NS;
  localparam int PXC_PULSE_100US_CYC = PXC_PULSE_100US_NS / PXC_CLK_PERIOD_NS;
  localparam int PXC_PULSE_1MS_CYC   = PXC_PULSE_1MS_NS / PXC_CLK_PERIOD_NS;
  localparam int PXC_PULSE_10MS_CYC  = PXC_PULSE_10MS_NS / PXC_CLK_PERIOD_NS;
  localparam int PXC_PULSE_CNT_W     = 22;

  // MAC interface modes, encoded as {reduced enable, clock direction}
  typedef enum logic [1:0] {
    PXC_MODE_MII,
    PXC_MODE_REV_REDUCED,
    PXC_MODE_REDUCED_TWO,
    PXC_MODE_REDUCED_ONE
  } pxc_if_mode_e;

endpackage

// ==== pxc_wake_irq.sv ====
/*
  Wake interrupt shaper: turns a wake hit into a level or a timed pulse.
  Assumes hit and clear are single-cycle strobes on clk.
*/
`timescale 1ns/100ps
`default_nettype none
module pxc_wake_irq
  import pxc_pkg::*;
#(
  parameter logic [PXC_PULSE_CNT_W-1:0] CYC_10US  = PXC_PULSE_CNT_W'(PXC_PULSE_10US_CYC),
  parameter logic [PXC_PULSE_CNT_W-1:0] CYC_100US = PXC_PULSE_CNT_W'(PXC_PULSE_100US_CYC),
  parameter logic [PXC_PULSE_CNT_W-1:0] CYC_1MS   = PXC_PULSE_CNT_W'(PXC_PULSE_1MS_CYC),
  parameter logic [PXC_PULSE_CNT_W-1:0] CYC_10MS  = PXC_PULSE_CNT_W'(PXC_PULSE_10MS_CYC)
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire logic       hit,        // Qualified wake hit
  input  wire logic       clear,      // Level mode acknowledge
  input  wire logic [2:0] shape,      // Shape field
  output logic            irq_q       // Wake interrupt
);

  logic [PXC_PULSE_CNT_W-1:0] cnt_q;  // Remaining pulse cycles
  logic [PXC_PULSE_CNT_W-1:0] width_w;

  // Width from the upper shape bits
  assign width_w = (shape[2:1] == 2'b00) ? CYC_10US  :
                   (shape[2:1] == 2'b01) ? CYC_100US :
                   (shape[2:1] == 2'b10) ? CYC_1MS   : CYC_10MS;

  // Pulse: high exactly width cycles; level: set wins over clear
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_q <= 1'b0;
      cnt_q <= '0;
    end else if (clk_en) begin
      if (hit) begin
        irq_q <= 1'b1;
        cnt_q <= width_w - 1'b1;
      end else if (shape[0]) begin
        if (irq_q && cnt_q == '0) irq_q <= 1'b0;
        else if (irq_q) cnt_q <= cnt_q - 1'b1;
      end else if (clear) begin
        irq_q <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ==== pxc_ext_regs.sv ====
/*
  Extended configuration register bank, reached through an indirect
  address/data pair on the management register port, plus the control
  logic that the bank steers. Assumes the management front end delivers
  single-cycle read/write strobes on clk; strap and clock pins are async.
*/
`timescale 1ns/100ps
`default_nettype none
module pxc_ext_regs
  import pxc_pkg::*;
#(
  parameter logic [PXC_PULSE_CNT_W-1:0] CYC_100US = PXC_PULSE_CNT_W'(PXC_PULSE_100US_CYC),
  parameter logic [PXC_PULSE_CNT_W-1:0] CYC_1MS   = PXC_PULSE_CNT_W'(PXC_PULSE_1MS_CYC),
  parameter logic [PXC_PULSE_CNT_W-1:0] CYC_10MS  = PXC_PULSE_CNT_W'(PXC_PULSE_10MS_CYC)
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  // Management register port
  input  wire logic        mgmt_wr,
  input  wire logic        mgmt_rd,
  input  wire logic [4:0]  mgmt_regad,
  input  wire logic [15:0] mgmt_wdata,
  output logic [15:0]      mgmt_rdata,
  // Straps and pins
  input  wire logic        clk_dir_strap,
  input  wire logic        receive_data_bit1_strap,
  input  wire logic        dac_clk_pin,
  // Device status inputs
  input  wire logic        ten_meg_mode,
  input  wire logic        tx_pending,
  input  wire logic        isolate,
  input  wire logic        crs_dv,
  input  wire logic        rx_dv,
  input  wire logic        rx_clk_int,
  input  wire logic        general_irq,
  input  wire logic        led_level,
  input  wire logic        wake_match,
  input  wire logic        wake_irq_clear,
  // Controls
  output logic             tx_dac_en,
  output logic             remote_loopback_en,
  output logic             long_frame_en,
  output logic [15:0]      rx_max_frame_len,
  output logic             crs_dv_out,
  output logic             wake_detect_en,
  output pxc_if_mode_e     mac_if_mode,
  output logic             tx_clk_oe_n,
  output logic             rx_clk_oe_n,
  output logic             rx_clk_out,
  output logic             led_irq_pin,
  output logic             wake_irq,
  output logic [1:0]       mac_if_drive_strength,
  output logic [1:0]       mgmt_pin_drive_strength,
  output logic [47:0]      wake_station_addr
);

  ////////////////////////////////////////////////////////////////////////
  // Storage
  logic [15:0] ind_addr_q;           // Indirect address
  logic [15:0] ten_meg_q;            // Power control
  logic [15:0] combo_q;              // Combo control
  logic [15:0] pad_q;                // Pad control
  logic [15:0] combo2_q;             // Combo control two
  logic [15:0] wake_hi_q;            // Wake address 47:32
  logic [15:0] wake_mid_q;           // Wake address 31:16
  logic [15:0] wake_lo_q;            // Wake address 15:0
  logic [1:0]  dir_sync_q;           // Clock direction strap sync
  logic [1:0]  irq_sync_q;           // Interrupt strap sync
  logic [1:0]  dac_sync_q;           // DAC clock pin sync
  logic        strap_done_q;         // Straps captured
  logic        irq_strap_q;          // Captured interrupt strap
  logic        tx_in_q;              // Transmit clock is an input
  logic        rx_in_q;              // Receive clock is an input

  ////////////////////////////////////////////////////////////////////////
  // Decode
  logic        data_wr_w;            // Write through the data register
  logic [15:0] ext_rd_w;             // Selected extended contents
  logic        reduced_w;            // Reduced enable bit: reduced two or reduced one mode
  logic        wake_hit_w;           // Qualified wake hit
  logic        dir_in_w;             // Direction bit asks for input

  function automatic logic ext_wr(input logic [15:0] off);
    return data_wr_w && ind_addr_q == off;
  endfunction

  // Contents move only through the data register
  assign data_wr_w = mgmt_wr && mgmt_regad == PXC_IND_DATA_REG;

  // Read selection; unmapped offsets read zero
  assign ext_rd_w = (ind_addr_q == PXC_TEN_MEG_PWR) ? ten_meg_q  :
                    (ind_addr_q == PXC_COMBO)       ? combo_q    :
                    (ind_addr_q == PXC_PAD)         ? pad_q      :
                    (ind_addr_q == PXC_COMBO_TWO)   ? combo2_q   :
                    (ind_addr_q == PXC_WAKE_HIGH)   ? wake_hi_q  :
                    (ind_addr_q == PXC_WAKE_MID)    ? wake_mid_q :
                    (ind_addr_q == PXC_WAKE_LOW)    ? wake_lo_q  : 16'h0000;

  assign reduced_w  = combo_q[PXC_REDUCED_BIT];
  assign dir_in_w   = combo_q[PXC_CLK_DIR_BIT];
  // Wake matching gated by the enable
  assign wake_hit_w = wake_match && combo_q[PXC_WAKE_EN_BIT];

  // Mode from {reduced enable, clock direction}
  assign mac_if_mode = pxc_if_mode_e'({reduced_w, dir_in_w});

  assign remote_loopback_en      = combo_q[PXC_LOOP_BIT];
  assign long_frame_en           = combo_q[PXC_LONG_FRAME_BIT];
  assign wake_detect_en          = combo_q[PXC_WAKE_EN_BIT];
  assign mac_if_drive_strength   = pad_q[PXC_MAC_DRV_LSB +: 2];
  assign mgmt_pin_drive_strength = pad_q[PXC_MGMT_DRV_LSB +: 2];
  assign wake_station_addr       = {wake_hi_q, wake_mid_q, wake_lo_q};
  assign tx_clk_oe_n             = tx_in_q;
  assign rx_clk_oe_n             = rx_in_q;

  ////////////////////////////////////////////////////////////////////////
  // Management port
  // Indirect address must be loaded before the data access
  always_ff @(posedge clk) begin
    if (rst) ind_addr_q <= 16'h0000;
    else if (clk_en && mgmt_wr && mgmt_regad == PXC_IND_ADDR_REG) ind_addr_q <= mgmt_wdata;
  end

  // Read data one cycle after the strobe; other register numbers read 0
  always_ff @(posedge clk) begin
    if (rst) mgmt_rdata <= 16'h0000;
    else if (clk_en && mgmt_rd) begin
      if (mgmt_regad == PXC_IND_ADDR_REG) mgmt_rdata <= ind_addr_q;
      else if (mgmt_regad == PXC_IND_DATA_REG) mgmt_rdata <= ext_rd_w;
      else mgmt_rdata <= 16'h0000;
    end
  end

  // Full words stored, reserved bits included
  always_ff @(posedge clk) begin
    if (rst) begin
      ten_meg_q  <= PXC_TEN_MEG_RST;
      pad_q      <= PXC_PAD_RST;
      combo2_q   <= PXC_COMBO2_RST;
      wake_hi_q  <= PXC_WAKE_RST;
      wake_mid_q <= PXC_WAKE_RST;
      wake_lo_q  <= PXC_WAKE_RST;
    end else if (clk_en) begin
      if (ext_wr(PXC_TEN_MEG_PWR)) ten_meg_q  <= mgmt_wdata;
      if (ext_wr(PXC_PAD))         pad_q      <= mgmt_wdata;
      if (ext_wr(PXC_COMBO_TWO))   combo2_q   <= mgmt_wdata;
      if (ext_wr(PXC_WAKE_HIGH))   wake_hi_q  <= mgmt_wdata;
      if (ext_wr(PXC_WAKE_MID))    wake_mid_q <= mgmt_wdata;
      if (ext_wr(PXC_WAKE_LOW))    wake_lo_q  <= mgmt_wdata;
    end
  end

  // Combo word; strap patches direction once after reset
  always_ff @(posedge clk) begin
    if (rst) combo_q <= PXC_COMBO_RST;
    else if (clk_en && !strap_done_q) combo_q[PXC_CLK_DIR_BIT] <= dir_sync_q[1];
    else if (clk_en && ext_wr(PXC_COMBO)) combo_q <= mgmt_wdata;
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; syncs run through reset so straps are settled
  always_ff @(posedge clk) begin
    if (clk_en) begin
      dir_sync_q <= {dir_sync_q[0], clk_dir_strap};
      irq_sync_q <= {irq_sync_q[0], receive_data_bit1_strap};
      dac_sync_q <= {dac_sync_q[0], dac_clk_pin};
    end
  end

  // Strap capture on the first enabled edge after release
  always_ff @(posedge clk) begin
    if (rst) begin
      strap_done_q <= 1'b0;
      irq_strap_q  <= 1'b0;
    end else if (clk_en && !strap_done_q) begin
      strap_done_q <= 1'b1;
      irq_strap_q  <= irq_sync_q[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Datapath controls
  // DAC gated off only in idle 10 Mb/s with gating set
  always_ff @(posedge clk) begin
    if (rst) tx_dac_en <= 1'b1;
    else if (clk_en)
      tx_dac_en <= !(ten_meg_mode && ten_meg_q[PXC_IDLE_GATE_BIT] && !tx_pending);
  end

  // Receive frame limit
  always_ff @(posedge clk) begin
    if (rst) rx_max_frame_len <= PXC_SHORT_FRAME_LEN;
    else if (clk_en)
      rx_max_frame_len <= long_frame_en ? PXC_LONG_FRAME_LEN : PXC_SHORT_FRAME_LEN;
  end

  // Carrier-valid pad; MII passes carrier sense through
  always_ff @(posedge clk) begin
    if (rst) crs_dv_out <= 1'b0;
    else if (clk_en)
      crs_dv_out <= (reduced_w && combo_q[PXC_CV_SRC_BIT]) ? rx_dv : crs_dv;
  end

  // Jitter test puts the sampled DAC clock on the receive clock
  always_ff @(posedge clk) begin
    if (rst) rx_clk_out <= 1'b0;
    else if (clk_en) rx_clk_out <= combo2_q[PXC_JITTER_BIT] ? dac_sync_q[1] : rx_clk_int;
  end

  // Clock directions; isolate may force input, else hold
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_in_q <= 1'b0;
      rx_in_q <= 1'b0;
    end else if (clk_en) begin
      if (!isolate) begin
        tx_in_q <= dir_in_w;
        rx_in_q <= dir_in_w;
      end else begin
        if (combo2_q[PXC_TX_ISO_BIT]) tx_in_q <= 1'b1;
        if (combo2_q[PXC_RX_ISO_BIT]) rx_in_q <= 1'b1;
      end
    end
  end

  // Shared LED pin; interrupt routing only under the strap
  always_ff @(posedge clk) begin
    if (rst) led_irq_pin <= 1'b0;
    else if (clk_en) begin
      if (!irq_strap_q) led_irq_pin <= led_level;
      else led_irq_pin <= pad_q[PXC_IRQ_SRC_BIT] ? general_irq : wake_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Wake interrupt shaping
  pxc_wake_irq #(
    .CYC_10US  (PXC_PULSE_CNT_W'(PXC_PULSE_10US_CYC)),
    .CYC_100US (CYC_100US),
    .CYC_1MS   (CYC_1MS),
    .CYC_10MS  (CYC_10MS)
  ) pxc_wake_irq_inst (
    .clk    (clk),
    .rst    (rst),
    .clk_en (clk_en),
    .hit    (wake_hit_w),
    .clear  (wake_irq_clear),
    .shape  (combo2_q[PXC_SHAPE_LSB +: 3]),
    .irq_q  (wake_irq)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  dac_gate_off_a: assert property (
    clk_en && ten_meg_mode && ten_meg_q[PXC_IDLE_GATE_BIT] && !tx_pending |=> !tx_dac_en)
    else $error("DAC not gated in idle 10M");
  dac_always_on_a: assert property (
    clk_en && (!ten_meg_q[PXC_IDLE_GATE_BIT] || tx_pending) |=> tx_dac_en)
    else $error("DAC off while it must be on");
  loop_write_a: assert property (
    clk_en && strap_done_q && ext_wr(PXC_COMBO) |=>
      remote_loopback_en == $past(mgmt_wdata[PXC_LOOP_BIT]))
    else $error("Loopback does not follow write");
  frame_limit_a: assert property (
    clk_en && long_frame_en |=> rx_max_frame_len == PXC_LONG_FRAME_LEN)
    else $error("Long frame limit wrong");
  carrier_src_a: assert property (
    clk_en && reduced_w && combo_q[PXC_CV_SRC_BIT] |=> crs_dv_out == $past(rx_dv))
    else $error("Carrier-valid source wrong");
  wake_gated_a: assert property (
    clk_en && !combo_q[PXC_WAKE_EN_BIT] && !wake_irq |=> !wake_irq)
    else $error("Wake interrupt while disabled");
  strap_capture_a: assert property (
    clk_en && !strap_done_q |=> combo_q[PXC_CLK_DIR_BIT] == $past(dir_sync_q[1]))
    else $error("Clock direction strap not captured");
  pin_route_a: assert property (
    clk_en && irq_strap_q && pad_q[PXC_IRQ_SRC_BIT] |=> led_irq_pin == $past(general_irq))
    else $error("Shared pin not general interrupt");
  tx_iso_in_a: assert property (
    clk_en && isolate && combo2_q[PXC_TX_ISO_BIT] |=> tx_clk_oe_n)
    else $error("Transmit clock not input under isolate");
  rx_iso_hold_a: assert property (
    clk_en && isolate && !combo2_q[PXC_RX_ISO_BIT] |=> $stable(rx_clk_oe_n))
    else $error("Receive clock direction changed under isolate");
  short_pulse_a: assert property (
    clk_en && wake_hit_w && combo2_q[PXC_SHAPE_LSB +: 3] == 3'b001 ##1 clk_en [*8] |-> wake_irq)
    else $error("Short wake pulse ended early");
  // Without a clear, a level-mode interrupt must not drop by itself
  level_hold_a: assert property (
    clk_en && wake_irq && !combo2_q[PXC_SHAPE_LSB] && !wake_irq_clear |=> wake_irq)
    else $error("Level wake interrupt dropped");
  short_limit_a: assert property (
    clk_en && !long_frame_en |=> rx_max_frame_len == PXC_SHORT_FRAME_LEN)
    else $error("Short frame limit wrong");
  jitter_route_a: assert property (
    clk_en && combo2_q[PXC_JITTER_BIT] |=> rx_clk_out == $past(dac_sync_q[1]))
    else $error("DAC clock not on receive clock");

  loop_entry_c: cover property (clk_en && $rose(remote_loopback_en));
  wake_pulse_c: cover property (combo2_q[PXC_SHAPE_LSB] && $fell(wake_irq));
  reduced_mode_c: cover property (mac_if_mode == PXC_MODE_REDUCED_TWO && crs_dv_out);

endmodule
`default_nettype wire

// ==== pxc_mgmt_model.sv ====
/*
  Station management controller model: reaches the extended bank
  through the indirect address/data pair with one-cycle strobes.
  Assumes it is driven on the falling edge of the device clock.
*/
`timescale 1ns/100ps
`default_nettype none
module pxc_mgmt_model
  import pxc_pkg::*;
(
  input  wire logic   clk,
  output logic        mgmt_wr,
  output logic        mgmt_rd,
  output logic [4:0]  mgmt_regad,
  output logic [15:0] mgmt_wdata
);
  // Idle at time zero
  initial begin
    {mgmt_wr, mgmt_rd, mgmt_regad, mgmt_wdata} = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One strobe; address and data lines go to the inverse after release so stale data
  // can never pass for a fresh value
  task automatic strobe(input logic w, input logic [4:0] ra, input logic [15:0] d);
    @(negedge clk);
    mgmt_wr    = w;
    mgmt_rd    = ~w;
    mgmt_regad = ra;
    mgmt_wdata = d;
    @(negedge clk);
    mgmt_wr    = 1'b0;
    mgmt_rd    = 1'b0;
    mgmt_regad = ~ra;
    mgmt_wdata = ~d;
  endtask

  // Address first, then contents through the data register
  task automatic ext_wr(input logic [15:0] off, input logic [15:0] d);
    strobe(1'b1, PXC_IND_ADDR_REG, off);
    strobe(1'b1, PXC_IND_DATA_REG, d);
  endtask

  task automatic ext_rd(input logic [15:0] off);
    strobe(1'b1, PXC_IND_ADDR_REG, off);
    strobe(1'b0, PXC_IND_DATA_REG, 16'h0000);
  endtask
endmodule
`default_nettype wire

// ==== pxc_ext_regs_tb.sv ====
/*
  Self-checking bench for the extended register bank.
  Assumes the management model drives the port; short pulse counts.
*/
`timescale 1ns/100ps
`default_nettype none
module pxc_ext_regs_tb
  import pxc_pkg::*;
;
  localparam int P100 = 20; // Shortened wake pulse widths
  localparam int P1M  = 30;
  localparam int P10M = 40;
  logic         clk, rst, clk_en, mgmt_wr, mgmt_rd, clk_dir_strap, receive_data_bit1_strap;
  logic         dac_clk_pin, ten_meg_mode, tx_pending, isolate, crs_dv, rx_dv, rx_clk_int;
  logic         general_irq, led_level, wake_match, wake_irq_clear, tx_dac_en;
  logic         remote_loopback_en, long_frame_en, crs_dv_out, wake_detect_en, rx_clk_out;
  logic         tx_clk_oe_n, rx_clk_oe_n, led_irq_pin, wake_irq, prev;
  logic [4:0]   mgmt_regad;
  logic [15:0]  mgmt_wdata, mgmt_rdata, rx_max_frame_len;
  logic [15:0]  offs [7], rstv [7], v [7];
  logic [1:0]   mac_if_drive_strength, mgmt_pin_drive_strength;
  logic [47:0]  wake_station_addr;
  pxc_if_mode_e mac_if_mode;
  logic [15:0]  exp_q [$]; // Expected read answers, oldest first
  int           err_total, comparisons, n, tn;
  int           wid [4];

  pxc_mgmt_model mdl (.clk, .mgmt_wr, .mgmt_rd, .mgmt_regad, .mgmt_wdata);
  pxc_ext_regs #(
    .CYC_100US (PXC_PULSE_CNT_W'(P100)),
    .CYC_1MS   (PXC_PULSE_CNT_W'(P1M)),
    .CYC_10MS  (PXC_PULSE_CNT_W'(P10M))
  ) pxc_ext_regs_inst (
    .clk, .rst, .clk_en, .mgmt_wr, .mgmt_rd, .mgmt_regad, .mgmt_wdata, .mgmt_rdata,
    .clk_dir_strap, .receive_data_bit1_strap, .dac_clk_pin, .ten_meg_mode, .tx_pending,
    .isolate, .crs_dv, .rx_dv, .rx_clk_int, .general_irq, .led_level, .wake_match,
    .wake_irq_clear, .tx_dac_en, .remote_loopback_en, .long_frame_en, .rx_max_frame_len,
    .crs_dv_out, .wake_detect_en, .mac_if_mode, .tx_clk_oe_n, .rx_clk_oe_n, .rx_clk_out,
    .led_irq_pin, .wake_irq, .mac_if_drive_strength, .mgmt_pin_drive_strength,
    .wake_station_addr);

  ////////////////////////////////////////////////////////////////////////////
  // Device clock, and a link clock of unrelated phase
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    dac_clk_pin = 1'b0;
    #1.3;
    forever #24 dac_clk_pin = ~dac_clk_pin;
  end
  // Watchdog so a stuck design still reaches the verdict
  initial begin
    #200000;
    err_total++;
    results();
  end

  task automatic chk(input logic [47:0] e, input logic [47:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  // Note the answer first; the monitor matches it when it appears
  task automatic rd(input logic [15:0] off, input logic [15:0] e);
    exp_q.push_back(e);
    mdl.ext_rd(off);
  endtask
  task automatic done();
    tn++;
    $display("test %0d done", tn);
  endtask
  task automatic results();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Read monitor: data is looked at one cycle after the taken strobe
  always @(posedge clk) begin
    if (mgmt_rd === 1'b1 && clk_en === 1'b1) begin
      @(posedge clk);
      @(negedge clk);
      chk(exp_q.pop_front(), mgmt_rdata);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, clk_en, clk_dir_strap, receive_data_bit1_strap} = 4'hf;
    {ten_meg_mode, tx_pending, isolate, crs_dv, rx_dv, rx_clk_int} = '0;
    {general_irq, led_level, wake_match, wake_irq_clear} = '0;
    offs = '{PXC_TEN_MEG_PWR, PXC_COMBO, PXC_PAD, PXC_COMBO_TWO,
             PXC_WAKE_HIGH, PXC_WAKE_MID, PXC_WAKE_LOW};
    rstv = '{PXC_TEN_MEG_RST, PXC_COMBO_RST | 16'h0001, PXC_PAD_RST, PXC_COMBO2_RST,
             PXC_WAKE_RST, PXC_WAKE_RST, PXC_WAKE_RST};
    wid = '{PXC_PULSE_10US_CYC, P100, P1M, P10M};
    void'($urandom(32'h2168a563));
    cyc(16);
    rst = 1'b0;
    cyc(3);
    // Reset values, strap on direction bit, unmapped offset
    for (int i = 0; i < 7; i++) rd(offs[i], rstv[i]);
    rd(16'h4002, 16'h0000);
    chk({tx_clk_oe_n, rx_clk_oe_n, mac_if_drive_strength, mgmt_pin_drive_strength}, 6'h3b);
    done();
    // Random write and read back, address assembly, refused writes
    for (int i = 0; i < 7; i++) begin
      v[i] = 16'($urandom);
      mdl.ext_wr(offs[i], v[i]);
    end
    for (int i = 0; i < 7; i++) rd(offs[i], v[i]);
    chk(wake_station_addr, {v[4], v[5], v[6]});
    chk({mac_if_drive_strength, mgmt_pin_drive_strength}, 4'(v[2][5:2]));
    mdl.ext_wr(16'h4002, 16'hffff);
    rd(16'h4002, 16'h0000);
    clk_en = 1'b0;
    mdl.ext_wr(PXC_WAKE_LOW, ~v[6]);
    clk_en = 1'b1;
    rd(PXC_WAKE_LOW, v[6]);
    done();
    // Every interface mode; loopback, long frames and wake enable set in the odd modes only
    for (int m = 0; m < 4; m++) begin
      mdl.ext_wr(PXC_COMBO, 16'(m) | (m[0] ? 16'h0824 : 16'h0000));
      cyc(2);
      chk({mac_if_mode, remote_loopback_en, long_frame_en, wake_detect_en, rx_max_frame_len},
          {2'(m), {3{m[0]}}, m[0] ? PXC_LONG_FRAME_LEN : PXC_SHORT_FRAME_LEN});
    end
    done();
    // Idle DAC gating in and out of 10 Mb/s operation
    mdl.ext_wr(PXC_TEN_MEG_PWR, PXC_TEN_MEG_RST | 16'h0400);
    cyc(2);
    chk(tx_dac_en, 1'b1);
    ten_meg_mode = 1'b1;
    cyc(2);
    chk(tx_dac_en, 1'b0);
    tx_pending = 1'b1;
    cyc(2);
    chk(tx_dac_en, 1'b1);
    tx_pending = 1'b0;
    mdl.ext_wr(PXC_TEN_MEG_PWR, PXC_TEN_MEG_RST);
    cyc(2);
    chk(tx_dac_en, 1'b1);
    done();
    // Carrier-valid source: the wrong source would give 0
    for (int k = 0; k < 2; k++) begin
      mdl.ext_wr(PXC_COMBO, 16'h0002 | 16'(k << 4));
      crs_dv = ~k[0];
      rx_dv = k[0];
      cyc(2);
      chk(crs_dv_out, 1'b1);
    end
    done();
    // Shared pin: general interrupt, then wake interrupt
    general_irq = 1'b1;
    mdl.ext_wr(PXC_PAD, PXC_PAD_RST);
    cyc(2);
    chk(led_irq_pin, 1'b1);
    mdl.ext_wr(PXC_PAD, PXC_PAD_RST & 16'h7fff);
    cyc(2);
    chk(led_irq_pin, 1'b0);
    done();
    // Wake: ignored while disabled, level until cleared, pulse widths
    mdl.ext_wr(PXC_COMBO, 16'h0000);
    mdl.ext_wr(PXC_COMBO_TWO, PXC_COMBO2_RST);
    pulse(wake_match);
    cyc(3);
    chk(wake_irq, 1'b0);
    mdl.ext_wr(PXC_COMBO, 16'h0004);
    pulse(wake_match);
    cyc(30);
    chk({wake_irq, led_irq_pin}, 2'b11);
    pulse(wake_irq_clear);
    cyc(2);
    chk(wake_irq, 1'b0);
    for (int w = 0; w < 4; w++) begin
      mdl.ext_wr(PXC_COMBO_TWO, 16'h00e0 | 16'(w << 8));
      pulse(wake_match);
      n = 0;
      // Pulse is already up at this negedge, so count before waiting
      for (int t = 0; t < 3000 && !(n > 0 && wake_irq === 1'b0); t++) begin
        n += int'(wake_irq === 1'b1);
        @(negedge clk);
      end
      chk(48'(n), 48'(wid[w]));
    end
    done();
    // Isolate: hold previous direction, then force both clocks to input
    mdl.ext_wr(PXC_COMBO, 16'h0000);
    mdl.ext_wr(PXC_COMBO_TWO, 16'h0200);
    isolate = 1'b1;
    mdl.ext_wr(PXC_COMBO, 16'h0001);
    cyc(3);
    chk({tx_clk_oe_n, rx_clk_oe_n}, 2'b00);
    mdl.ext_wr(PXC_COMBO_TWO, PXC_COMBO2_RST);
    cyc(3);
    chk({tx_clk_oe_n, rx_clk_oe_n}, 2'b11);
    isolate = 1'b0;
    done();
    // Jitter mux: receive clock output takes the link clock
    rx_clk_int = 1'b1;
    cyc(4);
    chk(rx_clk_out, 1'b1);
    mdl.ext_wr(PXC_COMBO_TWO, PXC_COMBO2_RST | 16'h4000);
    cyc(6);
    n = 0;
    prev = rx_clk_out;
    for (int t = 0; t < 100; t++) begin
      @(negedge clk);
      n += int'(rx_clk_out === 1'b1 && prev === 1'b0);
      prev = rx_clk_out;
    end
    chk(48'(n inside {[8:9]}), 48'h1);
    done();
    // Second reset with both straps low: clocks driven, LED level on pin
    clk_dir_strap = 1'b0;
    receive_data_bit1_strap = 1'b0;
    led_level = 1'b1;
    rst = 1'b1;
    cyc(16);
    rst = 1'b0;
    cyc(3);
    rd(PXC_COMBO, PXC_COMBO_RST);
    chk({tx_clk_oe_n, rx_clk_oe_n, led_irq_pin, remote_loopback_en}, 4'b0010);
    done();
    cyc(4);
    results();
  end
endmodule
`default_nettype wire
